// ### common/edl_regs.vh
// Constants for the embedded-data line formatter: tag bytes, script opcodes,
// fixed register values and the byte layout of the output word.
// Assumes it is included by bare name from the design files only.
`ifndef EDL_REGS_VH
`define EDL_REGS_VH

// Tag and filler bytes of the embedded stream.
`define EDL_FMT_CODE     8'h0A
`define EDL_TAG_IDX_HI   8'hAA
`define EDL_TAG_IDX_LO   8'hA5
`define EDL_TAG_VALUE    8'h5A
`define EDL_TAG_SKIP     8'h55
`define EDL_NULL_BYTE    8'h07

// Low bits appended to each byte in ten-bit output formats.
`define EDL_TEN_BIT_PAD  2'h1

// Script opcodes held in the sequence table.
`define EDL_OP_END       3'h0
`define EDL_OP_HI        3'h1
`define EDL_OP_LO        3'h2
`define EDL_OP_RUN       3'h3
`define EDL_OP_SKIP      3'h4

// Script table geometry; the second line's script starts here.
`define EDL_ROM_AW       6
`define EDL_ROW1_START   6'h1E

// Fixed values reported in place of the live register contents.
`define EDL_AGAIN_MAX_LO 8'h70
`define EDL_AGAIN_STEP_LO 8'h01
`define EDL_SCALE_N_LO   8'h10
`define EDL_DESC_HI_10   8'h0A
`define EDL_DESC_LO_10   8'h0A
`define EDL_DESC_HI_8    8'h08
`define EDL_DESC_LO_8    8'h08
`define EDL_WMARK_HI     8'h05
`define EDL_WMARK_LO     8'h10

`endif

// ### design/edl_skid_buffer.v
// Two-entry buffer between the byte generator and the output port.
// Assumes producer and consumer share clk; both sides use valid/ready.
`timescale 1ns/100ps

module edl_skid_buffer
#(
	parameter WIDTH = 11
)
(
	// Clock and reset.
	input  wire             clk,
	input  wire             nrst,
	// Filling side.
	input  wire             in_valid,
	input  wire [WIDTH-1:0] in_data,
	output wire             in_ready,
	// Draining side.
	output wire             out_valid,
	output wire [WIDTH-1:0] out_data,
	input  wire             out_ready
);

	reg             main_vld_r;
	reg [WIDTH-1:0] main_dat_r;
	reg             skid_vld_r;
	reg [WIDTH-1:0] skid_dat_r;

	// Ready is a flop so the generator never sees a combinational path from out_ready.
	assign in_ready  = ~skid_vld_r;
	assign out_valid = main_vld_r;
	assign out_data  = main_dat_r;

	// The skid slot catches the word accepted in the cycle the consumer stalled.
	always @(posedge clk)
	begin
		if (!nrst)
		begin
			main_vld_r <= 1'b0;
			main_dat_r <= {WIDTH{1'b0}};
			skid_vld_r <= 1'b0;
			skid_dat_r <= {WIDTH{1'b0}};
		end
		else if (!main_vld_r || out_ready)
		begin
			if (skid_vld_r)
			begin
				main_vld_r <= 1'b1;
				main_dat_r <= skid_dat_r;
				skid_vld_r <= 1'b0;
			end
			else
			begin
				main_vld_r <= in_valid;
				main_dat_r <= in_data;
			end
		end
		else if (in_valid && !skid_vld_r)
		begin
			skid_vld_r <= 1'b1;
			skid_dat_r <= in_data;
		end
	end

endmodule // edl_skid_buffer

// ### design/edl_script_rom.v
// Sequence table of the two embedded lines and the table of fixed values.
// Purely combinational; the formatter registers everything it reads here.
`timescale 1ns/100ps
`include "edl_regs.vh"

module edl_script_rom
(
	// Script lookup.
	input  wire [`EDL_ROM_AW-1:0] addr,
	output reg  [2:0]             op,
	output reg  [7:0]             arg,
	// Fixed value lookup by register index.
	input  wire [15:0]            index,
	output reg                    fix_hit,
	output reg  [7:0]             fix_val
);

	// Each entry is one opcode and its argument: page, low index or run length.
	always @*
	begin
		op  = `EDL_OP_END;
		arg = 8'h00;
		case (addr)
			6'h00: begin op = `EDL_OP_HI;   arg = 8'h00; end
			6'h01: begin op = `EDL_OP_LO;   arg = 8'h00; end
			6'h02: begin op = `EDL_OP_RUN;  arg = 8'h07; end
			6'h03: begin op = `EDL_OP_SKIP; arg = 8'h00; end
			6'h04: begin op = `EDL_OP_RUN;  arg = 8'h02; end
			6'h05: begin op = `EDL_OP_LO;   arg = 8'h0C; end
			6'h06: begin op = `EDL_OP_RUN;  arg = 8'h01; end
			6'h07: begin op = `EDL_OP_LO;   arg = 8'h40; end
			6'h08: begin op = `EDL_OP_RUN;  arg = 8'h1C; end
			6'h09: begin op = `EDL_OP_LO;   arg = 8'h80; end
			6'h0A: begin op = `EDL_OP_RUN;  arg = 8'h02; end
			6'h0B: begin op = `EDL_OP_LO;   arg = 8'h84; end
			6'h0C: begin op = `EDL_OP_RUN;  arg = 8'h10; end
			6'h0D: begin op = `EDL_OP_LO;   arg = 8'hC0; end
			6'h0E: begin op = `EDL_OP_RUN;  arg = 8'h10; end
			6'h0F: begin op = `EDL_OP_HI;   arg = 8'h01; end
			6'h10: begin op = `EDL_OP_LO;   arg = 8'h00; end
			6'h11: begin op = `EDL_OP_RUN;  arg = 8'h02; end
			6'h12: begin op = `EDL_OP_SKIP; arg = 8'h00; end
			6'h13: begin op = `EDL_OP_RUN;  arg = 8'h03; end
			6'h14: begin op = `EDL_OP_SKIP; arg = 8'h00; end
			6'h15: begin op = `EDL_OP_LO;   arg = 8'h10; end
			6'h16: begin op = `EDL_OP_RUN;  arg = 8'h04; end
			6'h17: begin op = `EDL_OP_LO;   arg = 8'h20; end
			6'h18: begin op = `EDL_OP_RUN;  arg = 8'h01; end
			6'h19: begin op = `EDL_OP_HI;   arg = 8'h02; end
			6'h1A: begin op = `EDL_OP_LO;   arg = 8'h00; end
			6'h1B: begin op = `EDL_OP_RUN;  arg = 8'h16; end
			6'h1C: begin op = `EDL_OP_END;  arg = 8'h00; end
			6'h1E: begin op = `EDL_OP_HI;   arg = 8'h03; end
			6'h1F: begin op = `EDL_OP_LO;   arg = 8'h00; end
			6'h20: begin op = `EDL_OP_RUN;  arg = 8'h0C; end
			6'h21: begin op = `EDL_OP_LO;   arg = 8'h40; end
			6'h22: begin op = `EDL_OP_RUN;  arg = 8'h10; end
			6'h23: begin op = `EDL_OP_LO;   arg = 8'h80; end
			6'h24: begin op = `EDL_OP_RUN;  arg = 8'h08; end
			6'h25: begin op = `EDL_OP_HI;   arg = 8'h04; end
			6'h26: begin op = `EDL_OP_LO;   arg = 8'h00; end
			6'h27: begin op = `EDL_OP_RUN;  arg = 8'h08; end
			6'h28: begin op = `EDL_OP_HI;   arg = 8'h05; end
			6'h29: begin op = `EDL_OP_LO;   arg = 8'h00; end
			6'h2A: begin op = `EDL_OP_RUN;  arg = 8'h02; end
			6'h2B: begin op = `EDL_OP_HI;   arg = 8'h06; end
			6'h2C: begin op = `EDL_OP_LO;   arg = 8'h00; end
			6'h2D: begin op = `EDL_OP_RUN;  arg = 8'h12; end
			6'h2E: begin op = `EDL_OP_HI;   arg = 8'h07; end
			6'h2F: begin op = `EDL_OP_LO;   arg = 8'h00; end
			6'h30: begin op = `EDL_OP_RUN;  arg = 8'h02; end
			default: begin op = `EDL_OP_END; arg = 8'h00; end
		endcase
	end

	// Indices whose reported value is a constant rather than the live register.
	always @*
	begin
		fix_hit = 1'b1;
		fix_val = 8'h00;
		case (index)
			16'h0087: fix_val = `EDL_AGAIN_MAX_LO;
			16'h0089: fix_val = `EDL_AGAIN_STEP_LO;
			16'h0407: fix_val = `EDL_SCALE_N_LO;
			16'h00C2: fix_val = `EDL_DESC_HI_10;
			16'h00C3: fix_val = `EDL_DESC_LO_10;
			16'h00C4: fix_val = `EDL_DESC_HI_10;
			16'h00C5: fix_val = `EDL_DESC_LO_8;
			16'h00C6: fix_val = `EDL_DESC_HI_8;
			16'h00C7: fix_val = `EDL_DESC_LO_8;
			16'h00C8, 16'h00C9, 16'h00CA, 16'h00CB,
			16'h00CC, 16'h00CD, 16'h00CE, 16'h00CF:
				fix_val = 8'h00;
			16'h0700: fix_val = `EDL_WMARK_HI;
			16'h0701: fix_val = `EDL_WMARK_LO;
			default: fix_hit = 1'b0;
		endcase
	end

endmodule // edl_script_rom

// ### design/embedded_data_line_formatter.v
// Embedded-data line formatter: builds the two tagged register lines that
// lead each output image and hands them out one pixel word per cycle.
// Assumes the register bank answers reg_value for reg_index in the same
// cycle, and that frame_start, embed_en and line_len come from clk logic.
// A line_len of zero closes a line only after 2^LEN_W words, when the count wraps; the caller keeps it at two or more.
`timescale 1ns/100ps
`include "edl_regs.vh"

module embedded_data_line_formatter
#(
	parameter LEN_W = 16
)
(
	// Clock and reset.
	input  wire             clk,
	input  wire             nrst,
	// Frame control.
	input  wire             frame_start,
	input  wire             embed_en,
	input  wire             ten_bit,
	input  wire [LEN_W-1:0] line_len,
	// Register bank lookup.
	output wire [15:0]      reg_index,
	input  wire [7:0]       reg_value,
	// Output pixel stream.
	output wire             out_valid,
	output wire [9:0]       out_data,
	output wire             out_last,
	input  wire             out_ready,
	// Status.
	output wire             busy
);

	// One-hot generator states.
	// Idle is bit 0, so the offer to the buffer is simply its inverse and
	// needs no decode of the other four bits.
	localparam ST_IDLE = 5'h01;
	localparam ST_FMT  = 5'h02;
	localparam ST_TAG  = 5'h04;
	localparam ST_ARG  = 5'h08;
	localparam ST_PAD  = 5'h10;

	reg  [4:0]             state_r;
	reg  [4:0]             state_nxt;
	reg  [`EDL_ROM_AW-1:0] rom_addr_r;
	reg  [`EDL_ROM_AW-1:0] rom_addr_nxt;
	reg                    row_r;
	reg                    row_nxt;
	reg  [LEN_W-1:0]       cnt_r;
	reg  [LEN_W-1:0]       cnt_nxt;
	reg  [LEN_W-1:0]       len_r;
	reg  [15:0]            idx_r;
	reg  [15:0]            idx_nxt;
	reg  [7:0]             run_left_r;
	reg  [7:0]             run_left_nxt;
	reg                    ten_bit_r;
	reg                    busy_r;
	reg  [7:0]             byte_val;

	wire [2:0]             op;
	wire [7:0]             arg;
	wire                   fix_hit;
	wire [7:0]             fix_val;
	wire                   gen_valid;
	wire                   gen_ready;
	wire                   fire;
	wire                   last_byte;
	wire [LEN_W-1:0]       remain;
	wire                   room_for_pair;
	wire                   script_done;
	wire [7:0]             value_byte;
	wire [9:0]             word;
	wire [7:0]             run_count;

	// The script moves one table entry per tag pair, except that a run entry
	// stays put until its count is used up. Holding the sequence in a table
	// rather than in states lets a register block be added without touching
	// the generator; the price is one table read in every byte cycle.

	// Sequence table and fixed-value lookup.
	edl_script_rom u_rom
	(
		.addr    (rom_addr_r),
		.op      (op),
		.arg     (arg),
		.index   (idx_r),
		.fix_hit (fix_hit),
		.fix_val (fix_val)
	);

	// A pair is only started when both of its bytes fit, so a tag is never
	// left at the end of a line without its argument. What does not fit is
	// dropped, not carried into the next line.
	// Byte position bookkeeping against the latched line length.
	assign remain        = len_r - cnt_r;
	assign last_byte     = (cnt_r + {{(LEN_W-1){1'b0}}, 1'b1}) == len_r;
	assign room_for_pair = remain >= {{(LEN_W-2){1'b0}}, 2'h2};
	assign script_done   = (op == `EDL_OP_END) || !room_for_pair;

	// A fixed table entry overrides the live bank value for that index.
	assign value_byte = fix_hit ? fix_val : reg_value;

	// A run resumes with its remaining count, or starts from the script entry.
	assign run_count = (run_left_r == 8'h00) ? arg : run_left_r;

	// The generator offers a byte in every state but idle; a stall in the
	// buffer freezes all bookkeeping until the byte is taken.
	assign gen_valid = ~state_r[0];
	assign fire      = gen_valid & gen_ready;

	// Choose the byte the generator offers this cycle.
	always @*
	begin
		byte_val = `EDL_NULL_BYTE;
		case (state_r)
			ST_FMT:
				byte_val = `EDL_FMT_CODE;
			ST_TAG:
			begin
				if (script_done)
					byte_val = `EDL_NULL_BYTE;
				else if (op == `EDL_OP_HI)
					byte_val = `EDL_TAG_IDX_HI;
				else if (op == `EDL_OP_LO)
					byte_val = `EDL_TAG_IDX_LO;
				else if (op == `EDL_OP_RUN)
					byte_val = `EDL_TAG_VALUE;
				else
					byte_val = `EDL_TAG_SKIP;
			end
			ST_ARG:
			begin
				if (op == `EDL_OP_HI || op == `EDL_OP_LO)
					byte_val = arg;
				else if (op == `EDL_OP_RUN)
					byte_val = value_byte;
				else
					byte_val = `EDL_NULL_BYTE;
			end
			ST_PAD:
				byte_val = `EDL_NULL_BYTE;
			default:
				byte_val = `EDL_NULL_BYTE;
		endcase
	end

	// Ten-bit formats put the byte on top and a fixed 01 below it.
	assign word = ten_bit_r ? {byte_val, `EDL_TEN_BIT_PAD} : {2'h0, byte_val};

	// Next-state logic; nothing moves unless the buffer took the byte.
	always @*
	begin
		state_nxt    = state_r;
		rom_addr_nxt = rom_addr_r;
		row_nxt      = row_r;
		cnt_nxt      = cnt_r;
		idx_nxt      = idx_r;
		run_left_nxt = run_left_r;
		if (fire)
		begin
			cnt_nxt = cnt_r + {{(LEN_W-1){1'b0}}, 1'b1};
			case (state_r)
				ST_FMT:
					state_nxt = ST_TAG;
				ST_TAG:
				begin
					if (script_done)
						state_nxt = ST_PAD;
					else
					begin
						state_nxt = ST_ARG;
						if (op == `EDL_OP_RUN)
							run_left_nxt = run_count;
					end
				end
				ST_ARG:
				begin
					state_nxt = ST_TAG;
					if (op == `EDL_OP_HI)
					begin
						idx_nxt[15:8] = arg;
						rom_addr_nxt  = rom_addr_r + {{(`EDL_ROM_AW-1){1'b0}}, 1'b1};
					end
					else if (op == `EDL_OP_LO)
					begin
						idx_nxt[7:0] = arg;
						rom_addr_nxt = rom_addr_r + {{(`EDL_ROM_AW-1){1'b0}}, 1'b1};
					end
					else if (op == `EDL_OP_RUN)
					begin
						idx_nxt      = idx_r + 16'h0001;
						run_left_nxt = run_left_r - 8'h01;
						if (run_left_r == 8'h01)
							rom_addr_nxt = rom_addr_r + {{(`EDL_ROM_AW-1){1'b0}}, 1'b1};
					end
					else
					begin
						idx_nxt      = idx_r + 16'h0001;
						rom_addr_nxt = rom_addr_r + {{(`EDL_ROM_AW-1){1'b0}}, 1'b1};
					end
				end
				ST_PAD:
					state_nxt = ST_PAD;
				default:
					state_nxt = ST_IDLE;
			endcase
			// The line closes on its last byte whatever state it was in.
			if (last_byte)
			begin
				cnt_nxt      = {LEN_W{1'b0}};
				run_left_nxt = 8'h00;
				if (!row_r)
				begin
					row_nxt      = 1'b1;
					rom_addr_nxt = `EDL_ROW1_START;
					state_nxt    = ST_FMT;
				end
				else
					state_nxt = ST_IDLE;
			end
		end
	end

	// State registers; a new frame is taken only while idle.
	// A frame_start that comes while the lines still run is dropped without
	// any sign, so the caller must wait for busy to fall.
	always @(posedge clk)
	begin
		if (!nrst)
		begin
			state_r    <= ST_IDLE;
			rom_addr_r <= {`EDL_ROM_AW{1'b0}};
			row_r      <= 1'b0;
			cnt_r      <= {LEN_W{1'b0}};
			len_r      <= {LEN_W{1'b0}};
			idx_r      <= 16'h0000;
			run_left_r <= 8'h00;
			ten_bit_r  <= 1'b0;
			busy_r     <= 1'b0;
		end
		else if (state_r == ST_IDLE)
		begin
			busy_r <= 1'b0;
			if (frame_start && embed_en)
			begin
				// Length and format are frozen for the whole embedded pair of lines.
				state_r    <= ST_FMT;
				rom_addr_r <= {`EDL_ROM_AW{1'b0}};
				row_r      <= 1'b0;
				cnt_r      <= {LEN_W{1'b0}};
				len_r      <= line_len;
				idx_r      <= 16'h0000;
				run_left_r <= 8'h00;
				ten_bit_r  <= ten_bit;
				busy_r     <= 1'b1;
			end
		end
		else
		begin
			state_r    <= state_nxt;
			rom_addr_r <= rom_addr_nxt;
			row_r      <= row_nxt;
			cnt_r      <= cnt_nxt;
			idx_r      <= idx_nxt;
			run_left_r <= run_left_nxt;
			busy_r     <= (state_nxt != ST_IDLE);
		end
	end

	// Stalls by the receiver hold the generator through gen_ready.
	// The last-word flag travels with its word, so it stays aligned with
	// out_data however long the receiver stalls.
	edl_skid_buffer
	#(
		.WIDTH (11)
	)
	u_buf
	(
		.clk       (clk),
		.nrst      (nrst),
		.in_valid  (gen_valid),
		.in_data   ({last_byte, word}),
		.in_ready  (gen_ready),
		.out_valid (out_valid),
		.out_data  ({out_last, out_data}),
		.out_ready (out_ready)
	);

	// Index and busy come straight from registers, so the register bank and
	// the frame sequencer outside never see a glitch.
	assign reg_index = idx_r;
	assign busy      = busy_r;

endmodule // embedded_data_line_formatter

// ### test/edl_host_rx.sv
// Host-side model: the register bank that answers reg_index and a stream receiver.
// Assumes one clock shared with the formatter and a bench that reads the capture memory.
`timescale 1ns/100ps

module edl_host_rx
(
	// Clock and reset.
	input  wire        clk,
	input  wire        nrst,
	// Bench controls.
	input  wire        stall,
	input  wire [7:0]  salt,
	// Register bank side.
	input  wire [15:0] reg_index,
	output wire [7:0]  reg_value,
	// Stream side.
	input  wire        out_valid,
	input  wire [9:0]  out_data,
	input  wire        out_last,
	output wire        out_ready,
	output reg  [11:0] rx_n
);
	reg [3:0] cnt_r;
	reg [9:0] rx_w [0:2047];
	reg       rx_l [0:2047];

	// Live values depend on the salt, so a second frame sees other contents.
	assign reg_value = reg_index[7:0] ^ reg_index[15:8] ^ salt;
	// Stalls last eight cycles, long enough to fill the two-entry buffer.
	assign out_ready = !(stall && cnt_r[3]);

	// Every accepted word is stored in order for the bench to judge.
	always @(posedge clk)
	begin
		cnt_r <= nrst ? cnt_r + 4'h1 : 4'h0;
		if (!nrst)
			rx_n <= 12'h000;
		else if (out_valid && out_ready)
		begin
			rx_w[rx_n] <= out_data;
			rx_l[rx_n] <= out_last;
			rx_n <= rx_n + 12'h001;
		end
	end
endmodule // edl_host_rx

// ### test/edl_formatter_checker.sv
// Concurrent checks on the ports of the embedded-data line formatter.
// Assumes line_len and ten_bit stay steady while a frame is in flight.
`timescale 1ns/100ps

module edl_formatter_checker
#(
	parameter LEN_W = 16
)
(
	// Clock and reset.
	input wire             clk,
	input wire             nrst,
	// Frame control.
	input wire             frame_start,
	input wire             embed_en,
	input wire             ten_bit,
	input wire [LEN_W-1:0] line_len,
	// Register bank lookup.
	input wire [15:0]      reg_index,
	input wire [7:0]       reg_value,
	// Output stream and status.
	input wire             out_valid,
	input wire [9:0]       out_data,
	input wire             out_last,
	input wire             out_ready,
	input wire             busy
);
	reg [LEN_W-1:0] wcnt_r;
	reg             mode_r;
	wire            take = frame_start && embed_en && !busy;
	wire [7:0]      byte_w = mode_r ? out_data[9:2] : out_data[7:0];

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!nrst);

	// Word position in the line and the word format of the running frame.
	always @(posedge clk)
	begin
		if (!nrst || take)
			wcnt_r <= {LEN_W{1'b0}};
		else if (out_valid && out_ready)
			wcnt_r <= out_last ? {LEN_W{1'b0}} : wcnt_r + {{(LEN_W-1){1'b0}}, 1'b1};
		if (!nrst)
			mode_r <= 1'b0;
		else if (take)
			mode_r <= ten_bit;
	end

	a_reset_quiet: assert property ($rose(nrst) |-> !out_valid && !busy && reg_index == 16'h0000)
		else $error("outputs not idle after reset");
	a_start_busy: assert property (take |=> busy)
		else $error("busy missing after frame start");
	a_first_fmt: assert property (take |-> ##2 out_valid &&
		out_data == ($past(ten_bit, 2) ? 10'h029 : 10'h00A))
		else $error("first word is not the format code");
	a_line_fmt: assert property (out_valid && wcnt_r == 0 |-> byte_w == 8'h0A)
		else $error("line does not start with the format code");
	a_last_count: assert property (out_valid && out_last |-> wcnt_r == line_len - 1'b1)
		else $error("last word at wrong position");
	a_hold_stall: assert property (out_valid && !out_ready |=>
		out_valid && $stable(out_data) && $stable(out_last))
		else $error("stalled word changed");
	a_refuse_off: assert property (frame_start && !embed_en && !busy |=> !busy)
		else $error("frame started while disabled");
	a_idle_quiet: assert property (!busy && !out_valid && !take |=> !out_valid)
		else $error("word offered while idle");
	a_ten_pad: assert property (out_valid && mode_r |-> out_data[1:0] == 2'b01)
		else $error("ten-bit low bits wrong");
	a_eight_pad: assert property (out_valid && !mode_r |-> out_data[9:8] == 2'b00)
		else $error("eight-bit upper bits not clear");

	c_stall: cover property (out_valid && !out_ready);
	c_last: cover property (out_valid && out_ready && out_last);
	c_ten_take: cover property (take && ten_bit);
endmodule // edl_formatter_checker

bind embedded_data_line_formatter edl_formatter_checker #(.LEN_W(LEN_W)) u_chk
(
	.clk(clk), .nrst(nrst), .frame_start(frame_start), .embed_en(embed_en),
	.ten_bit(ten_bit), .line_len(line_len), .reg_index(reg_index), .reg_value(reg_value),
	.out_valid(out_valid), .out_data(out_data), .out_last(out_last),
	.out_ready(out_ready), .busy(busy)
);

// ### test/testbench.sv
// Self-checking bench: whole frames are rebuilt from the tag rules and compared word by word.
// Assumes the host model captures every accepted word in order.
`timescale 1ns/100ps

module testbench;
	reg         clk, nrst, frame_start, embed_en, ten_bit, stall, halt;
	reg  [15:0] line_len;
	reg  [7:0]  salt;
	wire [15:0] reg_index;
	wire [7:0]  reg_value;
	wire        out_valid, out_last, out_ready, busy;
	wire [9:0]  out_data;
	wire [11:0] rx_n;
	integer     err_count, checked, n_exp, pos;
	reg  [9:0]  exp_w [0:1023];
	reg         exp_l [0:1023];
	// Index blocks of both lines, last block first; the line 1 blocks are 10 to 16.
	localparam [17*32-1:0] BLKS = {32'h07000701, 32'h06000611, 32'h05000501, 32'h04000407,
		32'h03800387, 32'h0340034F, 32'h0300030B, 32'h02000215, 32'h01200120, 32'h01100113,
		32'h01000106, 32'h00C000CF, 32'h00840093, 32'h00800081, 32'h0040005B, 32'h000C000C,
		32'h00000009};

	embedded_data_line_formatter u_embedded_data_line_formatter (.clk(clk), .nrst(nrst),
		.frame_start(frame_start), .embed_en(embed_en), .ten_bit(ten_bit),
		.line_len(line_len), .reg_index(reg_index), .reg_value(reg_value),
		.out_valid(out_valid), .out_data(out_data), .out_last(out_last),
		.out_ready(out_ready), .busy(busy));
	edl_host_rx u_edl_host_rx (.clk(clk), .nrst(nrst), .stall(stall), .salt(salt),
		.reg_index(reg_index), .reg_value(reg_value), .out_valid(out_valid),
		.out_data(out_data), .out_last(out_last), .out_ready(out_ready), .rx_n(rx_n));

	// Fixed entries win over the bank; every other entry is live.
	function [7:0] val(input [15:0] i);
		begin
			val = i[7:0] ^ i[15:8] ^ salt;
			if (i == 16'h0087) val = 8'h70;
			if (i == 16'h0089) val = 8'h01;
			if (i == 16'h0407) val = 8'h10;
			if (i >= 16'h00C2 && i <= 16'h00C4) val = 8'h0A;
			if (i >= 16'h00C5 && i <= 16'h00C7) val = 8'h08;
			if (i >= 16'h00C8 && i <= 16'h00CF) val = 8'h00;
			if (i == 16'h0700) val = 8'h05;
			if (i == 16'h0701) val = 8'h10;
		end
	endfunction

	task put(input [7:0] b);
		begin
			exp_w[n_exp] = ten_bit ? {b, 2'b01} : {2'b00, b};
			exp_l[n_exp] = (pos == line_len - 1);
			n_exp = n_exp + 1;
			pos = pos + 1;
		end
	endtask

	// A pair that no longer fits ends the script of this line.
	task pair(input [7:0] t, input [7:0] a);
		begin
			if (pos + 2 > line_len) halt = 1'b1;
			if (!halt) put(t);
			if (!halt) put(a);
		end
	endtask

	task build_line(input integer ln);
		integer b;
		reg [15:0] i, s;
		begin
			pos = 0;
			halt = 1'b0;
			put(8'h0A);
			for (b = ln * 10; b < (ln ? 17 : 10); b = b + 1)
			begin
				s = BLKS[b*32+16 +: 16];
				if (b == ln * 10 || s[15:8] != BLKS[b*32-8 +: 8]) pair(8'hAA, s[15:8]);
				pair(8'hA5, s[7:0]);
				for (i = s; i <= BLKS[b*32 +: 16]; i = i + 1)
					if (i == 16'h0007 || i == 16'h0102 || i == 16'h0106) pair(8'h55, 8'h07);
					else pair(8'h5A, val(i));
			end
			while (pos < line_len) put(8'h07);
		end
	endtask

	task chk(input [9:0] s, input [9:0] e, input [8*5-1:0] what);
		begin
			checked = checked + 1;
			if (s !== e)
			begin
				err_count = err_count + 1;
				$display("mismatch %0s expected %h seen %h", what, e, s);
			end
		end
	endtask

	task test_done;
		begin
			$display("checks %0d mismatches %0d", checked, err_count);
			if (err_count == 0 && checked > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask

	task pulse;
		begin
			frame_start = 1'b1;
			@(negedge clk);
			frame_start = 1'b0;
		end
	endtask

	// One frame; a second start while busy must be ignored.
	task run_frame(input [15:0] len, input tb, input [7:0] sl);
		integer k, base;
		begin
			line_len = len;
			ten_bit = tb;
			salt = sl;
			embed_en = 1'b1;
			n_exp = 0;
			build_line(0);
			build_line(1);
			base = rx_n;
			pulse;
			repeat (5) @(negedge clk);
			pulse;
			for (k = 0; k < 4000 && !(rx_n - base == n_exp && busy === 1'b0); k = k + 1)
				@(negedge clk);
			if (k == 4000)
			begin
				err_count = err_count + 1;
				$display("mismatch done expected 1 seen timeout");
				test_done;
			end
			repeat (8) @(negedge clk);
			chk(10'(rx_n - base), 10'(n_exp), "count");
			for (k = 0; k < n_exp; k = k + 1)
			begin
				chk(u_edl_host_rx.rx_w[base+k], exp_w[k], "word");
				chk({9'h000, u_edl_host_rx.rx_l[base+k]}, {9'h000, exp_l[k]}, "last");
			end
		end
	endtask

	task t_plain;
		begin
			run_frame(16'd260, 1'b0, 8'h00);
			$display("test plain done");
		end
	endtask

	task t_ten_stall;
		begin
			stall = 1'b1;
			run_frame(16'd250, 1'b1, 8'h5C);
			stall = 1'b0;
			$display("test ten_stall done");
		end
	endtask

	task t_short;
		begin
			run_frame(16'd10, 1'b0, 8'h21);
			$display("test short done");
		end
	endtask

	task t_refuse;
		integer base;
		begin
			base = rx_n;
			embed_en = 1'b0;
			pulse;
			repeat (8) @(negedge clk);
			chk({9'h000, busy}, 10'h000, "busy");
			chk(10'(rx_n - base), 10'h000, "count");
			$display("test refuse done");
		end
	endtask

	// A reset in mid-frame drops the lines and leaves the block idle.
	task t_reset;
		integer base;
		begin
			base = rx_n;
			line_len = 16'd260;
			ten_bit = 1'b0;
			embed_en = 1'b1;
			pulse;
			repeat (40) @(negedge clk);
			chk(u_edl_host_rx.rx_w[base], 10'h00A, "word");
			nrst = 1'b0;
			repeat (2) @(negedge clk);
			nrst = 1'b1;
			chk({9'h000, busy}, 10'h000, "busy");
			chk({9'h000, out_valid}, 10'h000, "valid");
			chk(reg_index[9:0], 10'h000, "index");
			chk(10'(rx_n), 10'h000, "count");
			$display("test reset done");
		end
	endtask

	// The clock runs at 50 MHz.
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial
	begin
		nrst = 1'b0;
		frame_start = 1'b0;
		embed_en = 1'b0;
		ten_bit = 1'b0;
		stall = 1'b0;
		line_len = 16'd260;
		salt = 8'h00;
		err_count = 0;
		checked = 0;
		repeat (12) @(negedge clk);
		nrst = 1'b1;
		@(negedge clk);
		t_refuse;
		t_plain;
		t_ten_stall;
		t_reset;
		t_short;
		test_done;
	end
endmodule // testbench
